// File: hdl/asp_pkg.sv
`default_nettype none
package asp_pkg;
	// ----------------------------------------------------------------
	// Frame layout and commands
	// ----------------------------------------------------------------
	localparam int          FRAME_BITS   = 16;
	localparam int          ANGLE_RES    = 12;
	localparam logic [2:0]  CMD_READ     = 3'h2;
	localparam logic [2:0]  CMD_WRITE    = 3'h4;
	localparam int          CMD_POS      = 13;
	localparam int          ADDR_POS     = 8;
	localparam int          NUM_REGS     = 32;
	localparam logic [4:0]  ADDR_ZERO_LO = 5'h00;
	localparam logic [4:0]  ADDR_ZERO_HI = 5'h01;
	localparam logic [4:0]  ADDR_THRESH  = 5'h06;
	localparam logic [4:0]  ADDR_DIR     = 5'h09;
	localparam logic [4:0]  ADDR_FLAGS   = 5'h1b;
	localparam logic [7:0]  THRESH_RST   = 8'h1c;
	localparam logic [7:0]  REG_RST      = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS  = 100;
	localparam int REFRESH_NS     = 1000;
	localparam int REFRESH_CYC    = REFRESH_NS / CLK_PERIOD_NS;
	localparam int TIMEOUT_NS     = 25000;
	localparam int TIMEOUT_CYC    = (TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEAD_NS        = 40000;
	localparam int DEAD_CYC       = (DEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ANGLE_GAP_NS   = 150;
	localparam int ANGLE_GAP_CYC  = (ANGLE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REG_GAP_NS     = 750;
	localparam int REG_GAP_CYC    = (REG_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int NVM_WAIT_MS    = 20;
	localparam int NVM_CYC        = NVM_WAIT_MS * (1000000 / CLK_PERIOD_NS);
	localparam int LINK_HALF_CYC  = 8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		OP_SPI_ANGLE = 2'h0,
		OP_REG_READ  = 2'h1,
		OP_REG_WRITE = 2'h2,
		OP_SSI_ANGLE = 2'h3
	} asp_op_t;

	typedef enum logic [1:0] {
		RESP_NONE  = 2'h0,
		RESP_READ  = 2'h1,
		RESP_WRITE = 2'h3
	} asp_resp_t;
endpackage : asp_pkg
`default_nettype wire

// File: hdl/asp_if.sv
`default_nettype none
interface asp_if;
	logic cs_n;
	logic sclk;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic ssck;
	logic ssd;

	modport dev (
		input  cs_n,
		input  sclk,
		input  mosi,
		input  ssck,
		output miso,
		output miso_oe,
		output ssd
	);

	modport host (
		output cs_n,
		output sclk,
		output mosi,
		output ssck,
		input  miso,
		input  miso_oe,
		input  ssd
	);
endinterface : asp_if
`default_nettype wire

// File: hdl/asp_device.sv
`default_nettype none
// Two-entry buffer; a full buffer drops in_ready so the source stalls.
module asp_buf2
	import asp_pkg::*;
#(
	parameter int W     = 16,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// Fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// Drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [W-1:0]  mem_q [DEPTH];
	logic [AW-1:0] wr_q;
	logic [AW-1:0] rd_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule : asp_buf2

// Overview of operation
// - Reload output buffer every microsecond unless frozen.
// - Chip select low freezes, high releases buffer.
// - Angle read: sixteen clocks, MSB first, MOSI zero.
// - Bits below useful resolution sent as zero.
// - Master may stop early for coarser angle.
// - Fast reads repeat value until buffer refresh.
// - Read request: command 010, address, zero byte.
// - Next frame returns register in upper byte.
// - Write request: command 100, address, value.
// - Next frame returns newly written value.
// - Twenty ms programming wait, earlier gives old.
// - No wait after reads or angle reads.
// - Writes persist; registers reload at power-on; reset here loads factory values.
// - Synchronous serial port reads angle only.
// - Serial master idles low, adds dummy rise.
// - First serial falling edge freezes, MSB first.
// - Serial freeze holds until bit zero plus timeout.
// - Serial word is sixteen bits, zero filled.
// - Master waits dead time between serial reads.
// - Mode 0 and 3 detected automatically.
// - Chip select high 150 ns between angles.
// - Chip select high 750 ns around registers.
module asp_device
	import asp_pkg::*;
#(
	parameter int NVM_PROG_CYC = NVM_CYC
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Link to the bus master
	asp_if.dev               link,
	// Angle samples from the front-end
	input  wire logic        angle_valid,
	output logic             angle_ready,
	input  wire logic [15:0] angle_data,
	// Field flags, readable at the flag address
	input  wire logic [1:0]  field_flags,
	// Stored configuration
	output logic [15:0]      zero_pos,
	output logic             dir_ccw,
	output logic [7:0]       field_thresh,
	output logic             prog_busy
);
	// ----------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------------------------------
	// Pin order: cs_n, sclk, mosi, ssck.
	logic [3:0] pin_s1_q;
	logic [3:0] pin_s2_q;
	logic [3:0] pin_s3_q;
	logic       cs_fall;
	logic       cs_rise;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       ssck_rise;
	logic       ssck_fall;
	logic       mosi_s;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_s1_q <= 4'h8;
			pin_s2_q <= 4'h8;
			pin_s3_q <= 4'h8;
		end else begin
			pin_s1_q <= {link.cs_n, link.sclk, link.mosi, link.ssck};
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	assign cs_fall   = pin_s3_q[3] && !pin_s2_q[3];
	assign cs_rise   = !pin_s3_q[3] && pin_s2_q[3];
	assign sclk_rise = !pin_s3_q[2] && pin_s2_q[2] && !pin_s2_q[3];
	assign sclk_fall = pin_s3_q[2] && !pin_s2_q[2] && !pin_s2_q[3];
	assign mosi_s    = pin_s2_q[1];
	assign ssck_rise = !pin_s3_q[0] && pin_s2_q[0];
	assign ssck_fall = pin_s3_q[0] && !pin_s2_q[0];

	// ----------------------------------------------------------------
	// Angle output buffer
	// ----------------------------------------------------------------
	localparam logic [15:0] RES_MASK = 16'hffff << (FRAME_BITS - ANGLE_RES);

	logic [3:0]  ref_cnt_q;
	logic        ref_tick;
	logic        spi_on_q;
	logic        ssi_on_q;
	logic        frozen;
	logic [15:0] angle_q;
	logic        fe_valid;
	logic [15:0] fe_data;

	assign frozen   = spi_on_q || ssi_on_q;
	assign ref_tick = (ref_cnt_q == 4'(REFRESH_CYC - 1));

	// The buffer absorbs front-end samples while a read holds the angle.
	asp_buf2 #(.W(16), .DEPTH(2)) u_fe_buf (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (angle_valid),
		.in_ready  (angle_ready),
		.in_data   (angle_data),
		.out_valid (fe_valid),
		.out_ready (ref_tick && !frozen),
		.out_data  (fe_data)
	);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ref_cnt_q <= '0;
			angle_q   <= '0;
		end else begin
			ref_cnt_q <= ref_tick ? '0 : ref_cnt_q + 4'h1;
			if (ref_tick && !frozen && fe_valid) begin
				angle_q <= fe_data & RES_MASK;
			end
		end
	end

	// ----------------------------------------------------------------
	// Configuration store
	// ----------------------------------------------------------------
	function automatic logic [7:0] reg_value(input logic [4:0] a, input logic [7:0] m, input logic [1:0] f);
		reg_value = (a == ADDR_FLAGS) ? {f, 6'h00} : m;
	endfunction : reg_value

	logic [7:0]  nvm_q [NUM_REGS];
	logic [19:0] prog_cnt_q;
	logic [4:0]  prog_addr_q;
	logic [7:0]  prog_data_q;
	logic        prog_start;
	logic [15:0] rx_q;

	// Reset stands in for power-on: the store comes back at factory values.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				nvm_q[i] <= (i == int'(ADDR_THRESH)) ? THRESH_RST : REG_RST;
			end
		end else if (prog_busy && prog_cnt_q == 20'(NVM_PROG_CYC - 1)) begin
			nvm_q[prog_addr_q] <= prog_data_q;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prog_busy   <= 1'b0;
			prog_cnt_q  <= '0;
			prog_addr_q <= '0;
			prog_data_q <= '0;
		end else if (prog_start) begin
			prog_busy   <= 1'b1;
			prog_cnt_q  <= '0;
			prog_addr_q <= rx_q[ADDR_POS +: 5];
			prog_data_q <= rx_q[7:0];
		end else if (prog_busy) begin
			prog_cnt_q <= prog_cnt_q + 20'h1;
			prog_busy  <= (prog_cnt_q != 20'(NVM_PROG_CYC - 1));
		end
	end

	assign zero_pos     = {nvm_q[ADDR_ZERO_HI], nvm_q[ADDR_ZERO_LO]};
	assign dir_ccw      = nvm_q[ADDR_DIR][7];
	assign field_thresh = nvm_q[ADDR_THRESH];

	// ----------------------------------------------------------------
	// Four-wire port
	// ----------------------------------------------------------------
	logic [15:0] tx_q;
	logic [4:0]  bit_cnt_q;
	logic        miso_q;
	asp_resp_t   resp_q;
	logic [4:0]  resp_addr_q;
	logic [15:0] frame_word;
	logic        full_frame;
	logic [2:0]  cmd;

	assign full_frame = (bit_cnt_q == 5'(FRAME_BITS));
	assign cmd        = rx_q[CMD_POS +: 3];
	assign prog_start = cs_rise && spi_on_q && full_frame && cmd == CMD_WRITE && !prog_busy;

	always_comb begin
		if (resp_q == RESP_NONE) begin
			frame_word = angle_q;
		end else begin
			frame_word = {reg_value(resp_addr_q, nvm_q[resp_addr_q], field_flags), 8'h00};
		end
	end

	// A falling clock edge shifts only after a rising one, so the idle-high
	// first edge of mode 3 never skips the MSB.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			spi_on_q    <= 1'b0;
			tx_q        <= '0;
			rx_q        <= '0;
			bit_cnt_q   <= '0;
			miso_q      <= 1'b0;
			resp_q      <= RESP_NONE;
			resp_addr_q <= '0;
		end else if (cs_fall) begin
			spi_on_q  <= 1'b1;
			tx_q      <= {frame_word[14:0], 1'b0};
			miso_q    <= frame_word[15];
			bit_cnt_q <= '0;
			rx_q      <= '0;
		end else if (cs_rise) begin
			spi_on_q <= 1'b0;
			resp_q   <= RESP_NONE;
			if (spi_on_q && full_frame) begin
				resp_addr_q <= rx_q[ADDR_POS +: 5];
				if (cmd == CMD_READ) begin
					resp_q <= RESP_READ;
				end else if (cmd == CMD_WRITE) begin
					resp_q <= RESP_WRITE;
				end
			end
		end else if (spi_on_q && sclk_rise) begin
			rx_q <= {rx_q[14:0], mosi_s};
			if (!full_frame) begin
				bit_cnt_q <= bit_cnt_q + 5'h1;
			end
		end else if (spi_on_q && sclk_fall && bit_cnt_q != '0) begin
			miso_q <= tx_q[15];
			tx_q   <= {tx_q[14:0], 1'b0};
		end
	end

	assign link.miso    = miso_q;
	assign link.miso_oe = spi_on_q;

	// ----------------------------------------------------------------
	// Two-wire angle port
	// ----------------------------------------------------------------
	logic [15:0] ss_tx_q;
	logic [8:0]  tmo_q;
	logic        ssd_q;

	// Only the angle is ever loaded here; no command path exists.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ssi_on_q  <= 1'b0;
			ss_tx_q   <= '0;
			tmo_q     <= '0;
			ssd_q     <= 1'b0;
		end else if (ssck_fall && !ssi_on_q) begin
			ssi_on_q  <= 1'b1;
			ssd_q     <= angle_q[15];
			ss_tx_q   <= {angle_q[14:0], 1'b0};
			tmo_q     <= 9'(TIMEOUT_CYC);
		end else if (ssi_on_q) begin
			if (ssck_fall) begin
				ssd_q   <= ss_tx_q[15];
				ss_tx_q <= {ss_tx_q[14:0], 1'b0};
				tmo_q   <= 9'(TIMEOUT_CYC);
			end else if (ssck_rise) begin
				// Every rise, the one for bit 0 included, restarts the quiet time.
				tmo_q <= 9'(TIMEOUT_CYC);
			end else if (tmo_q != '0) begin
				tmo_q <= tmo_q - 9'h1;
			end else begin
				// Release needs the quiet timeout, so an early stop also ends the hold.
				ssi_on_q <= 1'b0;
				ssd_q    <= 1'b0;
			end
		end
	end

	assign link.ssd = ssd_q;
endmodule : asp_device
`default_nettype wire

// File: hdl/asp_host.sv
`default_nettype none
module asp_host
	import asp_pkg::*;
#(
	parameter int NVM_WAIT_CYC = NVM_CYC
) (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// Link to the sensor
	asp_if.host              link,
	// Command port
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire asp_op_t     cmd_op,
	input  wire logic [4:0]  cmd_addr,
	input  wire logic [7:0]  cmd_data,
	// Answer port
	output logic             rsp_valid,
	input  wire logic        rsp_ready,
	output logic [15:0]      rsp_data
);
	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		H_IDLE  = 3'h0,
		H_SHIFT = 3'h1,
		H_GAP   = 3'h3,
		H_PUSH  = 3'h2
	} asp_hstate_t;

	asp_hstate_t state_q;
	asp_op_t     op_q;
	logic [1:0]  miso_s_q;
	logic [1:0]  ssd_s_q;
	logic [2:0]  div_q;
	logic [5:0]  half_q;
	logic [15:0] tx_q;
	logic [15:0] rx_q;
	logic [19:0] gap_q;
	logic        second_q;
	logic        cs_n_q;
	logic        sclk_q;
	logic        mosi_q;
	logic        ssck_q;
	logic        half_end;
	logic        is_ssi;
	logic        buf_ready;

	assign half_end = (div_q == 3'(LINK_HALF_CYC - 1));
	assign is_ssi   = (op_q == OP_SSI_ANGLE);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			miso_s_q <= '0;
			ssd_s_q  <= '0;
		end else begin
			miso_s_q <= {miso_s_q[0], link.miso};
			ssd_s_q  <= {ssd_s_q[0], link.ssd};
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q   <= H_IDLE;
			op_q      <= OP_SPI_ANGLE;
			cmd_ready <= 1'b0;
			div_q     <= '0;
			half_q    <= '0;
			tx_q      <= '0;
			rx_q      <= '0;
			gap_q     <= '0;
			second_q  <= 1'b0;
			cs_n_q    <= 1'b1;
			sclk_q    <= 1'b0;
			mosi_q    <= 1'b0;
			ssck_q    <= 1'b0;
		end else begin
			cmd_ready <= 1'b0;
			unique case (state_q)
				H_IDLE: begin
					if (cmd_valid && !cmd_ready) begin
						op_q     <= cmd_op;
						second_q <= 1'b0;
						div_q    <= '0;
						half_q   <= '0;
						state_q  <= H_SHIFT;
						unique case (cmd_op)
							OP_REG_READ:  tx_q <= {CMD_READ, cmd_addr, 8'h00};
							OP_REG_WRITE: tx_q <= {CMD_WRITE, cmd_addr, cmd_data};
							default:      tx_q <= '0;
						endcase
						if (cmd_op == OP_SSI_ANGLE) begin
							ssck_q <= 1'b1;
						end else begin
							cs_n_q <= 1'b0;
							mosi_q <= (cmd_op == OP_REG_READ) ? CMD_READ[2] : (cmd_op == OP_REG_WRITE) ? CMD_WRITE[2] : 1'b0;
						end
					end
				end
				H_SHIFT: begin
					div_q <= half_end ? '0 : div_q + 3'h1;
					if (half_end && half_q[0]) begin
						rx_q <= {rx_q[14:0], is_ssi ? ssd_s_q[1] : miso_s_q[1]};
					end
					if (half_end) begin
						half_q <= half_q + 6'h1;
						if (half_q == 6'(2 * FRAME_BITS)) begin
							state_q <= H_GAP;
							if (is_ssi) begin
								ssck_q <= 1'b0;
								gap_q  <= 20'(DEAD_CYC);
							end else begin
								cs_n_q <= 1'b1;
								mosi_q <= 1'b0;
								if (!second_q && op_q == OP_REG_WRITE) begin
									gap_q <= 20'(NVM_WAIT_CYC);
								end else if (op_q == OP_SPI_ANGLE) begin
									gap_q <= 20'(ANGLE_GAP_CYC);
								end else begin
									gap_q <= 20'(REG_GAP_CYC);
								end
							end
						end else if (is_ssi) begin
							ssck_q <= !ssck_q;
						end else begin
							sclk_q <= !sclk_q;
							if (half_q[0]) begin
								mosi_q <= tx_q[14];
								tx_q   <= {tx_q[14:0], 1'b0};
							end
						end
					end
				end
				H_GAP: begin
					if (gap_q != '0) begin
						gap_q <= gap_q - 20'h1;
					end else if (!second_q && (op_q == OP_REG_READ || op_q == OP_REG_WRITE)) begin
						second_q <= 1'b1;
						tx_q     <= '0;
						mosi_q   <= 1'b0;
						cs_n_q   <= 1'b0;
						div_q    <= '0;
						half_q   <= '0;
						state_q  <= H_SHIFT;
					end else begin
						state_q <= H_PUSH;
					end
				end
				H_PUSH: begin
					if (buf_ready) begin
						cmd_ready <= 1'b1;
						state_q   <= H_IDLE;
					end
				end
				default: state_q <= H_IDLE;
			endcase
		end
	end

	assign link.cs_n = cs_n_q;
	assign link.sclk = sclk_q;
	assign link.mosi = mosi_q;
	assign link.ssck = ssck_q;

	// ----------------------------------------------------------------
	// Answer buffer
	// ----------------------------------------------------------------
	asp_buf2 #(.W(16), .DEPTH(2)) u_rsp_buf (
		.clock     (clock),
		.rst       (rst),
		.in_valid  (state_q == H_PUSH),
		.in_ready  (buf_ready),
		.in_data   (rx_q),
		.out_valid (rsp_valid),
		.out_ready (rsp_ready),
		.out_data  (rsp_data)
	);
endmodule : asp_host
`default_nettype wire

// File: verif/asp_link_props.sv
`default_nettype none
module asp_link_props (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Link wires
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic ssck,
	input wire logic ssd
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// ----------------------------------------------------------------
	// Helper counters
	// ----------------------------------------------------------------
	logic       sclk_q;
	logic       cs_q;
	logic       ssck_q;
	logic [4:0] rises_q;
	logic [8:0] quiet_q;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			sclk_q  <= 1'b0;
			cs_q    <= 1'b1;
			rises_q <= 5'h00;
		end else begin
			sclk_q <= sclk;
			cs_q   <= cs_n;
			if (cs_n && cs_q)
				rises_q <= 5'h00;
			else if (sclk && !sclk_q)
				rises_q <= rises_q + 5'h01;
		end
	end

	// A serial clock that has not moved for a while means the serial frame is over.
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ssck_q  <= 1'b0;
			quiet_q <= 9'h000;
		end else begin
			ssck_q <= ssck;
			if (ssck != ssck_q)
				quiet_q <= 9'h000;
			else if (quiet_q != 9'h12c)
				quiet_q <= quiet_q + 9'h001;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_cs_quiet;
		cs_n [*8];
	endsequence
	sequence s_frame_end;
		$rose(cs_n);
	endsequence

	a_frame_rises: assert property (s_frame_end |-> rises_q == 5'h10)
		else $error("frame did not carry sixteen clock rises");
	a_cs_gap: assert property ($rose(cs_n) |-> cs_n [*2])
		else $error("chip select high gap too short");
	a_oe_on: assert property (!cs_n [*8] |-> miso_oe)
		else $error("miso not driven during selected frame");
	a_oe_off: assert property (s_cs_quiet |-> !miso_oe)
		else $error("miso driven while not selected");
	a_miso_hold: assert property ($rose(sclk) |=> $stable(miso) [*8])
		else $error("miso changed after a capture edge");
	a_sclk_idle: assert property (cs_n |-> !sclk)
		else $error("spi clock not low outside frame");
	a_ssck_idle: assert property (!cs_n |-> !ssck)
		else $error("serial clock moved during spi frame");
	a_ssd_release: assert property (quiet_q == 9'h12c |-> !ssd)
		else $error("serial data not idle after timeout");
	a_mosi_gap: assert property (s_cs_quiet |-> !mosi)
		else $error("mosi not low between frames");
endmodule : asp_link_props
`default_nettype wire

// File: verif/test_angle_sensor_serial_port.sv
`default_nettype none
module test_angle_sensor_serial_port;
	import asp_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------------------------------
	// Signals and instances
	// ----------------------------------------------------------------
	logic        clock;
	logic        rst;
	logic        angle_valid;
	logic        angle_ready;
	logic [15:0] angle_data;
	logic [1:0]  field_flags;
	logic [15:0] zero_pos;
	logic        dir_ccw;
	logic [7:0]  field_thresh;
	logic        prog_busy;
	logic        cmd_valid;
	logic        cmd_ready;
	asp_op_t     cmd_op;
	logic [4:0]  cmd_addr;
	logic [7:0]  cmd_data;
	logic        rsp_valid;
	logic        rsp_ready;
	logic [15:0] rsp_data;
	int          err_count;
	int          check_count;
	int          cycles;

	asp_if asp_if_inst ();

	asp_device #(.NVM_PROG_CYC(50)) asp_device_inst (
		.clock(clock), .rst(rst), .link(asp_if_inst),
		.angle_valid(angle_valid), .angle_ready(angle_ready), .angle_data(angle_data),
		.field_flags(field_flags), .zero_pos(zero_pos), .dir_ccw(dir_ccw),
		.field_thresh(field_thresh), .prog_busy(prog_busy)
	);

	// The host waits a little longer than the store needs, so no answer comes back stale.
	asp_host #(.NVM_WAIT_CYC(60)) asp_host_inst (
		.clock(clock), .rst(rst), .link(asp_if_inst),
		.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready), .rsp_data(rsp_data)
	);

	asp_link_props asp_link_props_inst (
		.clock(clock), .rst(rst), .cs_n(asp_if_inst.cs_n), .sclk(asp_if_inst.sclk),
		.mosi(asp_if_inst.mosi), .miso(asp_if_inst.miso), .miso_oe(asp_if_inst.miso_oe),
		.ssck(asp_if_inst.ssck), .ssd(asp_if_inst.ssd)
	);

	always #50 clock = ~clock;

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : close_out

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic set_angle(input logic [15:0] a);
		@(negedge clock);
		angle_data = a;
		repeat (40) @(negedge clock);
	endtask : set_angle

	task automatic issue(input asp_op_t op, input logic [4:0] addr, input logic [7:0] data);
		int i;
		@(negedge clock);
		cmd_op = op;
		cmd_addr = addr;
		cmd_data = data;
		cmd_valid = 1'b1;
		for (i = 0; i < 3000; i++) begin
			@(negedge clock);
			if (cmd_ready === 1'b1)
				break;
		end
		cmd_valid = 1'b0;
		check({15'h0000, cmd_ready}, 16'h0001);
	endtask : issue

	task automatic take(input logic [15:0] exp);
		int i;
		for (i = 0; i < 20; i++) begin
			if (rsp_valid === 1'b1)
				break;
			@(negedge clock);
		end
		check({15'h0000, rsp_valid}, 16'h0001);
		check(rsp_data, exp);
		rsp_ready = 1'b1;
		@(negedge clock);
		rsp_ready = 1'b0;
		// Let one edge pass so a following take never raises ready in this time step.
		@(negedge clock);
	endtask : take

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_angle;
		set_angle(16'h5a5f);
		issue(OP_SPI_ANGLE, 5'h00, 8'h00);
		check({8'h00, rsp_data[15:8]}, 16'h005a);
		take(16'h5a50);
		set_angle(16'hc3a9);
		issue(OP_SPI_ANGLE, 5'h00, 8'h00);
		take(16'hc3a0);
		$display("test angle done");
	endtask : t_angle

	task automatic t_reg_read;
		check({8'h00, field_thresh}, {8'h00, THRESH_RST});
		issue(OP_REG_READ, ADDR_THRESH, 8'h00);
		take({THRESH_RST, 8'h00});
		issue(OP_REG_READ, ADDR_FLAGS, 8'h00);
		take(16'h8000);
		$display("test register read done");
	endtask : t_reg_read

	task automatic t_write;
		issue(OP_REG_WRITE, ADDR_DIR, 8'h80);
		take(16'h8000);
		check({15'h0000, prog_busy}, 16'h0000);
		check({15'h0000, dir_ccw}, 16'h0001);
		issue(OP_REG_WRITE, ADDR_ZERO_LO, 8'hc7);
		take(16'hc700);
		check(zero_pos, 16'h00c7);
		issue(OP_REG_READ, ADDR_DIR, 8'h00);
		take(16'h8000);
		$display("test register write done");
	endtask : t_write

	task automatic t_ssi;
		set_angle(16'h1234);
		issue(OP_SSI_ANGLE, 5'h00, 8'h00);
		take(16'h1230);
		set_angle(16'hfedc);
		issue(OP_SSI_ANGLE, 5'h00, 8'h00);
		take(16'hfed0);
		$display("test serial angle done");
	endtask : t_ssi

	task automatic t_stall;
		set_angle(16'h1117);
		// A frozen buffer takes no samples, so the front-end must see a stall.
		fork
			issue(OP_SPI_ANGLE, 5'h00, 8'h00);
			begin
				repeat (100) @(negedge clock);
				repeat (12) begin
					@(negedge clock);
					check({15'h0000, angle_ready}, 16'h0000);
				end
			end
		join
		set_angle(16'h2228);
		issue(OP_SPI_ANGLE, 5'h00, 8'h00);
		check({15'h0000, rsp_valid}, 16'h0001);
		take(16'h1110);
		take(16'h2220);
		$display("test stall done");
	endtask : t_stall

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			err_count++;
			close_out();
		end
	end

	initial begin
		clock = 1'b0;
		rst = 1'b1;
		angle_valid = 1'b1;
		angle_data = 16'h0000;
		field_flags = 2'h2;
		cmd_valid = 1'b0;
		cmd_op = OP_SPI_ANGLE;
		cmd_addr = 5'h00;
		cmd_data = 8'h00;
		rsp_ready = 1'b0;
		err_count = 0;
		check_count = 0;
		cycles = 0;
		repeat (6) @(negedge clock);
		rst = 1'b0;
		t_angle();
		t_reg_read();
		t_write();
		t_ssi();
		t_stall();
		close_out();
	end
endmodule : test_angle_sensor_serial_port
`default_nettype wire
